// ---- inc/ulsl_pkg.sv ----
// shared constants for the line status logic of one uart channel
package ulsl_pkg;

   // bit positions inside line_state_flags
   localparam int LSF_RX_READY = 0;
   localparam int LSF_OVERRUN = 1;
   localparam int LSF_PARITY = 2;
   localparam int LSF_FRAMING = 3;
   localparam int LSF_BREAK = 4;
   localparam int LSF_THR_EMPTY = 5;
   localparam int LSF_TX_EMPTY = 6;
   localparam int LSF_FIFO_ERR = 7;

   // receive storage geometry
   localparam int RX_DEPTH = 64;
   localparam int RX_AW = 6;
   localparam int RX_CW = 7;
   localparam logic [6:0] RX_CAP_FIFO = 7'h40;
   localparam logic [6:0] RX_CAP_SINGLE = 7'h01;

   // one stored entry: {break, framing, parity, character}
   localparam int ENT_W = 11;
   localparam int ENT_PARITY = 8;
   localparam int ENT_FRAMING = 9;
   localparam int ENT_BREAK = 10;

   // character stored for a break
   localparam logic [7:0] BREAK_CHAR = 8'h00;

   // reset values and the idle bus value
   localparam logic [5:0] RST_PTR = 6'h00;
   localparam logic [6:0] RST_COUNT = 7'h00;
   localparam logic RST_OVERRUN = 1'b0;
   localparam logic RST_THR_EMPTY = 1'b1;
   localparam logic RST_TX_EMPTY = 1'b1;
   localparam logic [7:0] IDLE_BUS = 8'h00;

endpackage : ulsl_pkg

// ---- src/ulsl_line_state.sv ----
`timescale 1ns/100ps
module ulsl_line_state
   import ulsl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic fifo_en_i,
   input wire logic rx_fifo_reset_i,
   input wire logic rx_push_i,
   input wire logic [7:0] rx_char_i,
   input wire logic rx_break_i,
   input wire logic rx_framing_i,
   input wire logic rx_parity_i,
   input wire logic tx_holding_empty_i,
   input wire logic tx_shift_empty_i,
   input wire logic lsr_rd_i,
   input wire logic rhr_rd_i,
   output logic [7:0] host_data_bus_o,
   output logic rx_full_o,
   output logic [6:0] rx_level_o
);

   // the three error tags of an entry, break first
   function automatic logic [2:0] ent_tags(input logic [ENT_W-1:0] ent);
      ent_tags = {ent[ENT_BREAK], ent[ENT_FRAMING], ent[ENT_PARITY]};
   endfunction : ent_tags

   // true when an entry carries any of the three error tags
   function automatic logic tag_any(input logic [ENT_W-1:0] ent);
      tag_any = |ent_tags(ent);
   endfunction : tag_any

   // receive storage; no reset, every read is gated by the level
   logic [ENT_W-1:0] rx_mem [RX_DEPTH];

   logic [RX_AW-1:0] wr_ptr_q;
   logic [RX_AW-1:0] wr_ptr_d;
   logic [RX_AW-1:0] rd_ptr_q;
   logic [RX_AW-1:0] rd_ptr_d;
   logic [RX_CW-1:0] level_q;
   logic [RX_CW-1:0] level_d;
   logic [RX_CW-1:0] err_cnt_q;
   logic [RX_CW-1:0] err_cnt_d;
   logic overrun_q;
   logic overrun_d;
   logic thr_empty_q;
   logic thr_empty_d;
   logic tx_empty_q;
   logic tx_empty_d;

   logic [RX_CW-1:0] capacity;
   logic rx_empty;
   logic rx_full;
   logic pop;
   logic push;
   logic overrun_set;
   logic [ENT_W-1:0] head;
   logic [ENT_W-1:0] new_ent;
   logic [2:0] head_tags;
   logic [7:0] status;

   // storage occupancy and head entry
   always_comb
   begin
      // with the fifo off, one character fills the storage
      capacity = fifo_en_i ? RX_CAP_FIFO : RX_CAP_SINGLE;
      rx_empty = (level_q == RST_COUNT);
      rx_full = (level_q >= capacity);
      head = rx_mem[rd_ptr_q];
   end

   // the two access strobes
   always_comb
   begin
      // data read pops
      // a status read in the same cycle wins the bus, so no pop then
      pop = rhr_rd_i & ~lsr_rd_i & ~rx_empty;
      // a pop in the same cycle frees the slot the push needs
      push = rx_push_i & (~rx_full | pop);
      overrun_set = rx_push_i & rx_full & ~pop;
   end

   // entry built from the receiver strobe
   always_comb
   begin
      new_ent = '0;
      new_ent[ENT_PARITY] = rx_parity_i;
      new_ent[ENT_FRAMING] = rx_framing_i;
      new_ent[ENT_BREAK] = rx_break_i;
      new_ent[7:0] = rx_break_i ? BREAK_CHAR : rx_char_i;
   end

   // next pointer and level
   always_comb
   begin
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      level_d = level_q;
      if (rx_fifo_reset_i)
      begin
         // flush drops every entry; the words themselves stay stale
         wr_ptr_d = RST_PTR;
         rd_ptr_d = RST_PTR;
         level_d = RST_COUNT;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_d = wr_ptr_q + 6'h01;
         end
         if (pop)
         begin
            rd_ptr_d = rd_ptr_q + 6'h01;
         end
         case ({push, pop})
            2'b10: level_d = level_q + 7'h01;
            2'b01: level_d = level_q - 7'h01;
            default: level_d = level_q;
         endcase
      end
   end

   // next tagged entry count
   always_comb
   begin
      if (rx_fifo_reset_i)
      begin
         // flush drops every error tag with its entry
         err_cnt_d = RST_COUNT;
      end
      else
      begin
         // count tagged entries in storage
         // a count, not a scan, so bit 7 needs no 64-way or tree
         case ({push & tag_any(new_ent), pop & tag_any(head)})
            2'b10: err_cnt_d = err_cnt_q + 7'h01;
            2'b01: err_cnt_d = err_cnt_q - 7'h01;
            default: err_cnt_d = err_cnt_q;
         endcase
      end
   end

   // next overrun flag
   always_comb
   begin
      // status read clears
      // a new overrun in the clearing cycle wins over the clear
      if (overrun_set)
      begin
         overrun_d = 1'b1;
      end
      else if (lsr_rd_i)
      begin
         overrun_d = 1'b0;
      end
      else
      begin
         overrun_d = overrun_q;
      end
   end

   // next transmit state; the bits trail their inputs by one clock
   always_comb
   begin
      thr_empty_d = tx_holding_empty_i;
      tx_empty_d = tx_holding_empty_i & tx_shift_empty_i;
   end

   // pointer and level registers
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr_q <= RST_PTR;
         rd_ptr_q <= RST_PTR;
         level_q <= RST_COUNT;
      end
      else
      begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         level_q <= level_d;
      end
   end

   // tagged entry count register
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         err_cnt_q <= RST_COUNT;
      end
      else
      begin
         err_cnt_q <= err_cnt_d;
      end
   end

   // overrun register
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         overrun_q <= RST_OVERRUN;
      end
      else
      begin
         overrun_q <= overrun_d;
      end
   end

   // transmit state registers
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         thr_empty_q <= RST_THR_EMPTY;
         tx_empty_q <= RST_TX_EMPTY;
      end
      else
      begin
         thr_empty_q <= thr_empty_d;
         tx_empty_q <= tx_empty_d;
      end
   end

   // storage write port
   always_ff @(posedge clk_i)
   begin
      if (push && !rx_fifo_reset_i)
      begin
         rx_mem[wr_ptr_q] <= new_ent;
      end
   end

   // status word assembled at read time
   always_comb
   begin
      // tags straight from head
      // taken from the head entry, so they track each pop at once
      head_tags = rx_empty ? 3'h0 : ent_tags(head);
      status = '0;
      status[LSF_FIFO_ERR] = (err_cnt_q != RST_COUNT);
      status[LSF_TX_EMPTY] = tx_empty_q;
      status[LSF_THR_EMPTY] = thr_empty_q;
      status[LSF_BREAK] = head_tags[2];
      status[LSF_FRAMING] = head_tags[1];
      status[LSF_PARITY] = head_tags[0];
      status[LSF_OVERRUN] = overrun_q;
      status[LSF_RX_READY] = ~rx_empty;
   end

   // read data bus; combinational so the tags never sit in a flop
   always_comb
   begin
      if (lsr_rd_i)
      begin
         host_data_bus_o = status;
      end
      else if (pop)
      begin
         host_data_bus_o = head[7:0];
      end
      else
      begin
         host_data_bus_o = IDLE_BUS;   // idle or read of empty storage
      end
   end

   // occupancy seen by the receiver and flow control
   assign rx_full_o = rx_full;
   assign rx_level_o = level_q;

endmodule : ulsl_line_state

// ---- sim/ulsl_host_model.sv ----
`timescale 1ns/100ps
// host: one or both strobes per request, bus caught under them
module ulsl_host_model
(
   input wire logic clk_i,
   input wire logic [1:0] op_i,
   input wire logic [7:0] bus_i,
   output logic lsr_rd_o,
   output logic rhr_rd_o,
   output logic [7:0] data_o
);
   assign lsr_rd_o = op_i[0];
   assign rhr_rd_o = op_i[1];
   // bus only valid under a strobe
   always_ff @(posedge clk_i)
   begin
      if (op_i != 2'h0)
         data_o <= bus_i;
   end
endmodule : ulsl_host_model

// ---- sim/ulsl_line_state_assertions.sv ----
`timescale 1ns/100ps
// status read, idle bus and flush checks
module ulsl_line_state_chk
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic rx_fifo_reset_i,
   input wire logic rx_push_i,
   input wire logic tx_holding_empty_i,
   input wire logic tx_shift_empty_i,
   input wire logic lsr_rd_i,
   input wire logic rhr_rd_i,
   input wire logic [7:0] host_data_bus_o,
   input wire logic rx_full_o,
   input wire logic [6:0] rx_level_o
);
   wire sr = lsr_rd_i;
   wire [7:0] st = host_data_bus_o;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   property p_idle; !sr && !rhr_rd_i |-> st == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("bus not idle");
   property p_rdy; sr |-> st[0] == (rx_level_o != 7'h00); endproperty
   a_rdy: assert property (p_rdy) else $error("ready bit");
   property p_err; sr && rx_level_o == 7'h00 |->
      st[7] == 1'b0 && st[4:2] == 3'h0; endproperty
   a_err: assert property (p_err) else $error("error bits");
   property p_txe; sr && $past(rst_n_i) |->
      st[6] == $past(tx_holding_empty_i && tx_shift_empty_i); endproperty
   a_txe: assert property (p_txe) else $error("tx empty");
   property p_thre; sr && $past(rst_n_i) |->
      st[5] == $past(tx_holding_empty_i); endproperty
   a_thre: assert property (p_thre) else $error("holding empty");
   property p_keep; sr && !rx_push_i && !rx_fifo_reset_i |=>
      $stable(rx_level_o); endproperty
   a_keep: assert property (p_keep) else $error("level moved");
   property p_ovr; rx_push_i && rx_full_o && !rhr_rd_i ##1 !sr ##1 sr
      |-> st[1]; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun lost");
   property p_ovc; sr && !rx_push_i ##1 !rx_push_i ##1 sr |-> !st[1];
   endproperty
   a_ovc: assert property (p_ovc) else $error("overrun kept");
   property p_flush; rx_fifo_reset_i |=> rx_level_o == 7'h00; endproperty
   a_flush: assert property (p_flush) else $error("flush kept data");
   c_ovr: cover property (sr && st[1]);
   c_flush: cover property (rx_fifo_reset_i);
   c_brk: cover property (sr && st[4]);
   c_txe: cover property (sr && !st[6]);
endmodule : ulsl_line_state_chk
bind ulsl_line_state ulsl_line_state_chk u_chk (.*);

// ---- sim/ulsl_line_state_bench.sv ----
`timescale 1ns/100ps
module ulsl_line_state_bench;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic fifo_en_i = 1'b1;
   logic rx_push_i = 1'b0;
   logic [7:0] rx_char_i = 8'h00;
   logic [2:0] tag = 3'h0;
   logic [1:0] txe = 2'h3;
   logic [1:0] op = 2'h0;
   logic flush = 1'b0;
   logic lsr_rd, rhr_rd;
   logic [7:0] bus, got;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   ulsl_line_state uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .fifo_en_i(fifo_en_i), .rx_fifo_reset_i(flush),
      .rx_push_i(rx_push_i), .rx_char_i(rx_char_i), .rx_break_i(tag[2]),
      .rx_framing_i(tag[1]), .rx_parity_i(tag[0]),
      .tx_holding_empty_i(txe[1]), .tx_shift_empty_i(txe[0]),
      .lsr_rd_i(lsr_rd), .rhr_rd_i(rhr_rd), .host_data_bus_o(bus),
      .rx_full_o(), .rx_level_o());
   ulsl_host_model host (.clk_i(clk_i), .op_i(op), .bus_i(bus),
      .lsr_rd_o(lsr_rd), .rhr_rd_o(rhr_rd), .data_o(got));
   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // one read: 1 status, 2 data
   task automatic rd(input logic [1:0] k, input logic [7:0] e,
      input string w);
      @(posedge clk_i) op <= k;
      @(posedge clk_i) op <= 2'h0;
      #1 comparisons++;
      if (got !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", w, e, got);
      end
   endtask : rd
   task automatic push(input logic [7:0] c, input logic [2:0] t);
      @(posedge clk_i) rx_push_i <= 1'b1;
      rx_char_i <= c;
      tag <= t;
      @(posedge clk_i) rx_push_i <= 1'b0;
   endtask : push
   initial forever #10 clk_i = ~clk_i;
   // hang guard, run needs about 56 cycles
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 500)
      begin
         err_count++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(2'h1, 8'h60, "reset status");
      push(8'h41, 3'h1);
      push(8'h55, 3'h4);
      push(8'h3c, 3'h2);
      rd(2'h1, 8'he5, "parity head");
      rd(2'h1, 8'he5, "status again");
      rd(2'h2, 8'h41, "first char");
      rd(2'h1, 8'hf1, "break head");
      rd(2'h2, 8'h00, "break char");
      rd(2'h1, 8'he9, "framing head");
      rd(2'h2, 8'h3c, "third char");
      rd(2'h1, 8'h60, "errors gone");
      $display("receive test done");
      @(posedge clk_i) txe <= 2'h2;
      rd(2'h1, 8'h20, "shift busy");
      @(posedge clk_i) txe <= 2'h0;
      rd(2'h1, 8'h00, "holding full");
      @(posedge clk_i) txe <= 2'h3;
      fifo_en_i <= 1'b0;
      $display("transmit test done");
      push(8'h11, 3'h0);
      push(8'h22, 3'h0);
      rd(2'h1, 8'h63, "overrun set");
      rd(2'h1, 8'h61, "overrun gone");
      rd(2'h2, 8'h11, "kept char");
      $display("overrun test done");
      push(8'h5a, 3'h1);
      rd(2'h3, 8'he5, "both strobes");
      rd(2'h2, 8'h5a, "char after both");
      push(8'h66, 3'h2);
      @(posedge clk_i) flush <= 1'b1;
      @(posedge clk_i) flush <= 1'b0;
      rd(2'h1, 8'h60, "flushed");
      $display("flush test done");
      end_of_test();
   end
endmodule : ulsl_line_state_bench
